// >>> verilog/disk_format_command_handler.sv
// apb-reached task file and format command sequencer
// assumes an external media engine acknowledging one sector write per ack
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module disk_format_command_handler (
    input wire logic CLK_SYS_IN,
    input wire logic RST_N_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    output logic MEDIA_WRITE_OUT,
    output logic [27:0] MEDIA_LBA_OUT,
    input wire logic MEDIA_ACK_IN,
    input wire logic MEDIA_FAULT_IN,
    output logic IRQ_OUT
);
    fmt_pkg::taskfile_t tf;
    fmt_pkg::state_t state;
    logic [7:0] failure;
    logic busy;
    logic erase_armed;
    logic [7:0] irq_stat;
    logic [7:0] irq_mask;
    logic [7:0] reassigned;
    logic [15:0] defects;
    logic [7:0] table_seen;
    logic [27:0] cur_lba;
    logic [27:0] end_lba;
    logic [27:0] req_lba;
    logic [27:0] chs_lba;
    logic [5:0] sect_in_track;
    logic out_of_range;
    logic wr_en;
    logic rd_en;
    logic op_wr;
    logic done_evt;
    logic err_evt;
    logic range_miss;
    logic [7:0] condition;

    assign wr_en = PSEL_IN & PENABLE_IN & PWRITE_IN;
    assign rd_en = PSEL_IN & PENABLE_IN & ~PWRITE_IN;
    assign PREADY_OUT = 1'b1;
    assign op_wr = wr_en && PADDR_IN == fmt_pkg::ADDR_OPCODE && !busy;

    // lba decode from three address bytes and head field
    assign req_lba = {tf.devhead[3:0], tf.high, tf.mid, tf.low}; // see RULE5 RULE6
    // chs: cylinder*heads+head, times sectors per track
    assign chs_lba = 28'((({12'h000, tf.high, tf.mid} * 28'(fmt_pkg::HEADS + 5'h01)
        + 28'(tf.devhead[3:0])) * 28'(fmt_pkg::SECT_PER_TRACK))); // see RULE7
    assign out_of_range = tf.devhead[fmt_pkg::DH_LBA]
        ? (req_lba > fmt_pkg::NATIVE_MAX_LBA)
        : ({tf.high, tf.mid} >= fmt_pkg::CYLINDERS); // see RULE9
    assign sect_in_track = 6'(req_lba % 28'(fmt_pkg::SECT_PER_TRACK));

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state <= fmt_pkg::S_IDLE;
            cur_lba <= fmt_pkg::ZERO_LBA;
            end_lba <= fmt_pkg::ZERO_LBA;
        end else begin
            case (state)
                fmt_pkg::S_IDLE: begin
                    if (op_wr && PWDATA_IN[7:0] == fmt_pkg::OP_FORMAT_TRACK) begin
                        if (out_of_range) begin
                            state <= fmt_pkg::S_ABORT;
                        end else if (tf.devhead[fmt_pkg::DH_LBA]) begin
                            // whole track holding the lba, same layout always
                            cur_lba <= req_lba - 28'(sect_in_track); // see RULE10 RULE4
                            end_lba <= req_lba - 28'(sect_in_track)
                                + 28'(fmt_pkg::SECT_PER_TRACK) - 28'h0000001;
                            state <= fmt_pkg::S_TRACK;
                        end else begin
                            cur_lba <= chs_lba;
                            end_lba <= chs_lba + 28'(fmt_pkg::SECT_PER_TRACK)
                                - 28'h0000001;
                            state <= fmt_pkg::S_TRACK;
                        end
                    end else if (op_wr &&
                        PWDATA_IN[7:0] == fmt_pkg::OP_FORMAT_UNIT) begin
                        // feature value is not checked: all others reserved
                        if (!erase_armed) begin
                            state <= fmt_pkg::S_ABORT; // see RULE14
                        end else begin
                            state <= fmt_pkg::S_MERGE; // see RULE11
                        end
                    end
                end
                fmt_pkg::S_MERGE: begin
                    // geometry and max-address limits ignored here
                    cur_lba <= fmt_pkg::ZERO_LBA;
                    end_lba <= fmt_pkg::NATIVE_MAX_LBA; // see RULE13
                    state <= fmt_pkg::S_UNIT;
                end
                fmt_pkg::S_TRACK, fmt_pkg::S_UNIT: begin
                    // write only; no verify pass follows
                    if (MEDIA_FAULT_IN) begin
                        state <= fmt_pkg::S_ABORT;
                    end else if (MEDIA_ACK_IN) begin // see RULE2
                        if (cur_lba == end_lba) begin
                            state <= fmt_pkg::S_DONE;
                        end else begin
                            cur_lba <= cur_lba + 28'h0000001;
                        end
                    end
                end
                fmt_pkg::S_DONE, fmt_pkg::S_ABORT: begin
                    state <= fmt_pkg::S_IDLE;
                end
                default: begin
                    state <= fmt_pkg::S_IDLE;
                end
            endcase
        end
    end

    assign busy = state != fmt_pkg::S_IDLE;
    assign done_evt = state == fmt_pkg::S_DONE;
    assign err_evt = state == fmt_pkg::S_ABORT;

    // zero data is implied: engine writes zeros at the given lba
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            MEDIA_WRITE_OUT <= 1'b0;
            MEDIA_LBA_OUT <= fmt_pkg::ZERO_LBA;
        end else begin
            MEDIA_WRITE_OUT <= (state == fmt_pkg::S_TRACK
                || state == fmt_pkg::S_UNIT) && !MEDIA_ACK_IN
                && !MEDIA_FAULT_IN; // see RULE1
            MEDIA_LBA_OUT <= cur_lba;
        end
    end

    // task file: host writes, device writes back the current address after an lba-mode track format only
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            tf <= '0;
        end else if (done_evt && state == fmt_pkg::S_DONE
            && tf.devhead[fmt_pkg::DH_LBA] && end_lba != fmt_pkg::NATIVE_MAX_LBA) begin
            tf.low <= cur_lba[7:0]; // see RULE8
            tf.mid <= cur_lba[15:8];
            tf.high <= cur_lba[23:16];
            tf.devhead[3:0] <= cur_lba[27:24];
        end else if (wr_en && !busy) begin
            case (PADDR_IN)
                fmt_pkg::ADDR_FEATURE: tf.feature <= PWDATA_IN[7:0];
                fmt_pkg::ADDR_COUNT: tf.count <= PWDATA_IN[7:0];
                fmt_pkg::ADDR_LOW: tf.low <= PWDATA_IN[7:0];
                fmt_pkg::ADDR_MID: tf.mid <= PWDATA_IN[7:0];
                fmt_pkg::ADDR_HIGH: tf.high <= PWDATA_IN[7:0];
                fmt_pkg::ADDR_DEVHEAD: tf.devhead <= PWDATA_IN[7:0];
                default: begin
                end
            endcase
        end
    end

    // format table port: stored byte count only, contents never used
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            table_seen <= 8'h00;
        end else if (wr_en && PADDR_IN == fmt_pkg::ADDR_TABLE) begin
            table_seen <= table_seen + 8'h01; // see RULE3
        end
    end

    // erase-prepare arms the next opcode only
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            erase_armed <= 1'b0;
        end else if (op_wr) begin
            erase_armed <= PWDATA_IN[7:0] == fmt_pkg::OP_ERASE_PREP; // see RULE14
        end
    end

    // defect list: reassignments merged then cleared before the fill
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            reassigned <= 8'h00;
            defects <= 16'h0000;
        end else if (state == fmt_pkg::S_MERGE) begin
            defects <= defects + {8'h00, reassigned}; // see RULE11 RULE12
            reassigned <= 8'h00;
        end else if (wr_en && !busy && PADDR_IN == fmt_pkg::ADDR_DEFECTS) begin
            reassigned <= PWDATA_IN[7:0];
        end
    end

    // error register, cleared at each new command
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            failure <= 8'h00;
            range_miss <= 1'b0;
        end else if (op_wr) begin
            failure <= 8'h00;
            // only a track opcode can miss its target; a stale address
            // left in the task file must not flag other aborts
            range_miss <= PWDATA_IN[7:0] == fmt_pkg::OP_FORMAT_TRACK
                && out_of_range && tf.devhead[fmt_pkg::DH_LBA];
        end else if (err_evt) begin
            failure[fmt_pkg::ERR_ABT] <= 1'b1; // see RULE9 RULE14
            failure[fmt_pkg::ERR_IDN] <= range_miss;
        end
    end

    // status: busy clears at completion, fault and fixed stay low
    always_comb begin
        condition = 8'h00;
        condition[fmt_pkg::ST_BSY] = busy; // see RULE18
        condition[fmt_pkg::ST_RDY] = 1'b1;
        condition[fmt_pkg::ST_DF] = 1'b0;
        condition[fmt_pkg::ST_DSC] = !busy;
        // no data phase for either command
        condition[fmt_pkg::ST_DRQ] = 1'b0; // see RULE16
        condition[fmt_pkg::ST_COR] = 1'b0;
        condition[fmt_pkg::ST_ERR] = |failure; // see RULE18
    end

    // sticky interrupt status; set wins over write-one clear
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            irq_stat <= 8'h00;
        end else begin
            irq_stat <= (irq_stat & ~((wr_en && PADDR_IN == fmt_pkg::ADDR_IRQ_STAT)
                ? PWDATA_IN[7:0] : 8'h00))
                | (done_evt ? fmt_pkg::IRQ_DONE : 8'h00)
                | (err_evt ? fmt_pkg::IRQ_ERR : 8'h00);
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            irq_mask <= 8'h00;
        end else if (wr_en && PADDR_IN == fmt_pkg::ADDR_IRQ_MASK) begin
            irq_mask <= PWDATA_IN[7:0];
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            IRQ_OUT <= 1'b0;
        end else begin
            IRQ_OUT <= |(irq_stat & irq_mask);
        end
    end

    // read mux; unmapped reads zero with slverr
    always_comb begin
        PRDATA_OUT = 32'h00000000;
        PSLVERR_OUT = 1'b0;
        if (rd_en) begin
            case (PADDR_IN)
                fmt_pkg::ADDR_COUNT: PRDATA_OUT[7:0] = tf.count;
                fmt_pkg::ADDR_LOW: PRDATA_OUT[7:0] = tf.low;
                fmt_pkg::ADDR_MID: PRDATA_OUT[7:0] = tf.mid;
                fmt_pkg::ADDR_HIGH: PRDATA_OUT[7:0] = tf.high;
                fmt_pkg::ADDR_DEVHEAD: PRDATA_OUT[7:0] = tf.devhead;
                fmt_pkg::ADDR_FAILURE: PRDATA_OUT[7:0] = failure;
                fmt_pkg::ADDR_CONDITION: PRDATA_OUT[7:0] = condition;
                fmt_pkg::ADDR_IRQ_STAT: PRDATA_OUT[7:0] = irq_stat;
                fmt_pkg::ADDR_IRQ_MASK: PRDATA_OUT[7:0] = irq_mask;
                fmt_pkg::ADDR_DEFECTS: PRDATA_OUT[15:0] = defects;
                fmt_pkg::ADDR_TABLE: PRDATA_OUT[7:0] = table_seen;
                default: PSLVERR_OUT = 1'b1;
            endcase
        end
    end
endmodule

// >>> verilog/fmt_pkg.sv
// constants, types and register map of the disk format command handler
// assumes an apb master and a media engine that zero-fills one sector
// Operation
// RULE1: track format zero-fills every good sector
// RULE2: write only, no read-back verify
// RULE3: format table data accepted then ignored
// RULE4: fixed layout, one-to-one interleave
// RULE5: lba bits 0-23 in three address bytes
// RULE6: head field holds lba bits 24-27
// RULE7: lba bit clear: cylinder and head addressing
// RULE8: completion returns current 28-bit address; the code writes it back only after an lba-mode track format
// RULE9: out-of-range address aborts track format
// RULE10: track containing the lba is formatted
// RULE11: unit format merges reassigns, clears, initialises
// RULE12: new defect info valid at completion
// RULE13: unit format covers lba 0 to native max
// RULE14: unit format aborted without erase prepare
// RULE15: host writes feature value 11h
// RULE16: unit format never raises transfer request
// RULE17: host timeout from identify word 89
// RULE18: completion clears busy, fault, fixed flags
// RULE19: host sets device/head bits 7 and 5
package fmt_pkg;
    localparam logic [7:0] ADDR_FEATURE = 8'h00;
    localparam logic [7:0] ADDR_COUNT = 8'h04;
    localparam logic [7:0] ADDR_LOW = 8'h08;
    localparam logic [7:0] ADDR_MID = 8'h0C;
    localparam logic [7:0] ADDR_HIGH = 8'h10;
    localparam logic [7:0] ADDR_DEVHEAD = 8'h14;
    localparam logic [7:0] ADDR_OPCODE = 8'h18;
    localparam logic [7:0] ADDR_FAILURE = 8'h1C;
    localparam logic [7:0] ADDR_CONDITION = 8'h20;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h24;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;
    localparam logic [7:0] ADDR_DEFECTS = 8'h2C;
    localparam logic [7:0] ADDR_TABLE = 8'h30;

    localparam logic [7:0] OP_FORMAT_TRACK = 8'h50;
    localparam logic [7:0] OP_FORMAT_UNIT = 8'hF7;
    localparam logic [7:0] OP_ERASE_PREP = 8'hF3;

    // failure_cause bits
    localparam int ERR_UNC = 6;
    localparam int ERR_IDN = 4;
    localparam int ERR_ABT = 2;
    // drive_condition bits
    localparam int ST_BSY = 7;
    localparam int ST_RDY = 6;
    localparam int ST_DF = 5;
    localparam int ST_DSC = 4;
    localparam int ST_DRQ = 3;
    localparam int ST_COR = 2;
    localparam int ST_ERR = 0;
    // drive_and_head_select fields
    localparam int DH_LBA = 6;
    localparam int DH_DRV = 4;

    // geometry and capacity, plain defaults
    localparam logic [27:0] NATIVE_MAX_LBA = 28'h00FFFFF;
    localparam logic [5:0] SECT_PER_TRACK = 6'h3F;
    localparam logic [3:0] HEADS = 4'hF;
    localparam logic [15:0] CYLINDERS = 16'h0410;
    localparam logic [27:0] ZERO_LBA = 28'h0000000;
    localparam logic [7:0] IRQ_DONE = 8'h01;
    localparam logic [7:0] IRQ_ERR = 8'h02;

    typedef struct packed {
        logic [7:0] feature;
        logic [7:0] count;
        logic [7:0] low;
        logic [7:0] mid;
        logic [7:0] high;
        logic [7:0] devhead;
    } taskfile_t;

    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_TRACK = 6'h02,
        S_MERGE = 6'h04,
        S_UNIT = 6'h08,
        S_DONE = 6'h10,
        S_ABORT = 6'h20
    } state_t;
endpackage

// >>> bench/media_model.sv
// media engine model: zero-fills one sector per request
// assumes the handler holds its request until ack or fault
`timescale 1ns/1ps
module media_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic write_in,
    input wire logic [27:0] lba_in,
    input wire logic [27:0] fault_lba_in,
    output logic ack_out,
    output logic fault_out
);
    int pseed = 9;
    int wait_cnt;
    int lim;
    // answer delay varies so prompt and slow media both occur
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_out <= 1'b0;
            fault_out <= 1'b0;
            wait_cnt <= 0;
            lim <= 0;
        end else if (ack_out || fault_out) begin
            ack_out <= 1'b0;
            fault_out <= 1'b0;
        end else if (write_in) begin
            if (wait_cnt >= lim) begin
                wait_cnt <= 0;
                lim <= $random(pseed) & 3;
                ack_out <= (lba_in != fault_lba_in);
                fault_out <= (lba_in == fault_lba_in);
            end else begin
                wait_cnt <= wait_cnt + 1;
            end
        end
    end
endmodule

// >>> bench/fmt_checker.sv
// port assertions for the format command handler
// assumes binding onto disk_format_command_handler
`timescale 1ns/1ps
module fmt_checker (
    input wire logic CLK_SYS_IN,
    input wire logic RST_N_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic PSLVERR_OUT,
    input wire logic MEDIA_WRITE_OUT,
    input wire logic [27:0] MEDIA_LBA_OUT,
    input wire logic MEDIA_ACK_IN,
    input wire logic MEDIA_FAULT_IN,
    input wire logic IRQ_OUT
);
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RST_N_IN);
    logic [1:0] ack_age;
    logic [27:0] last_lba;
    wire rd = PSEL_IN && PENABLE_IN && !PWRITE_IN;
    wire st_rd = rd && PADDR_IN == fmt_pkg::ADDR_CONDITION;
    wire irq_wr = PSEL_IN && PENABLE_IN && PWRITE_IN && (PADDR_IN ==
        fmt_pkg::ADDR_IRQ_STAT || PADDR_IN == fmt_pkg::ADDR_IRQ_MASK);
    // short window: a new command never starts this soon after an ack
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ack_age <= 2'h0;
            last_lba <= 28'h0;
        end else if (MEDIA_WRITE_OUT && MEDIA_ACK_IN) begin
            ack_age <= 2'h3;
            last_lba <= MEDIA_LBA_OUT;
        end else if (ack_age != 2'h0) begin
            ack_age <= ack_age - 2'h1;
        end
    end
    sequence s_waiting;
        MEDIA_WRITE_OUT && !MEDIA_ACK_IN && !MEDIA_FAULT_IN;
    endsequence
    sequence s_done;
        MEDIA_WRITE_OUT && MEDIA_ACK_IN;
    endsequence
    chk_req_holds: assert property (
        s_waiting |=> MEDIA_WRITE_OUT && $stable(MEDIA_LBA_OUT))
        else $error("media request dropped or moved");
    chk_req_drops: assert property (
        s_done |=> !MEDIA_WRITE_OUT)
        else $error("media request held after ack");
    chk_lba_ascend: assert property (
        $rose(MEDIA_WRITE_OUT) && ack_age != 2'h0 |->
        MEDIA_LBA_OUT == last_lba + 28'h1)
        else $error("sector order broken");
    chk_stat_fixed: assert property (
        st_rd |-> (PRDATA_OUT[7:0] & 8'h6C) == 8'h40)
        else $error("status flags wrong");
    chk_dsc_busy: assert property (
        st_rd |-> PRDATA_OUT[fmt_pkg::ST_DSC] != PRDATA_OUT[fmt_pkg::ST_BSY])
        else $error("seek flag not inverse of busy");
    chk_unmapped_err: assert property (
        rd && PADDR_IN > fmt_pkg::ADDR_TABLE |-> PSLVERR_OUT)
        else $error("no error on unmapped read");
    chk_upper_zero: assert property (
        rd |-> PRDATA_OUT[31:16] == 16'h0 && (PRDATA_OUT[15:8] == 8'h0
        || PADDR_IN == fmt_pkg::ADDR_DEFECTS))
        else $error("read data upper bits set");
    chk_irq_sticky: assert property (
        IRQ_OUT && !irq_wr && !$past(irq_wr) |=> IRQ_OUT)
        else $error("interrupt dropped without clear");
endmodule
bind disk_format_command_handler fmt_checker i_chk (
    .CLK_SYS_IN(CLK_SYS_IN), .RST_N_IN(RST_N_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PRDATA_OUT(PRDATA_OUT), .PSLVERR_OUT(PSLVERR_OUT),
    .MEDIA_WRITE_OUT(MEDIA_WRITE_OUT), .MEDIA_LBA_OUT(MEDIA_LBA_OUT),
    .MEDIA_ACK_IN(MEDIA_ACK_IN), .MEDIA_FAULT_IN(MEDIA_FAULT_IN),
    .IRQ_OUT(IRQ_OUT));

// >>> bench/tb_disk_format_command_handler.sv
// self-checking bench for the format command handler
// assumes the media model answers every sector request
`timescale 1ns/1ps
module tb_disk_format_command_handler;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, m_wr, m_ack, m_flt, irq;
    logic [27:0] m_lba, a;
    logic [27:0] flt_lba = 28'hFFFFFFF;
    logic [15:0] c;
    logic [7:0] last_rd;
    logic [63:0] rd_q[$];
    logic [27:0] lba_q[$];
    int error_cnt = 0;
    int num_checks = 0;
    int seed = 62;

    disk_format_command_handler i_dut (
        .CLK_SYS_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .MEDIA_WRITE_OUT(m_wr),
        .MEDIA_LBA_OUT(m_lba), .MEDIA_ACK_IN(m_ack),
        .MEDIA_FAULT_IN(m_flt), .IRQ_OUT(irq));
    media_model i_media (
        .clk_in(clk), .rst_n_in(rst_n), .write_in(m_wr), .lba_in(m_lba),
        .fault_lba_in(flt_lba), .ack_out(m_ack), .fault_out(m_flt));

    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic apb(input logic [7:0] ad, input logic w, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        apb(ad, 1'b1, d);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] e, m);
        rd_q.push_back({m, e});
        apb(ad, 1'b0, 8'h00);
    endtask
    task automatic wait_idle();
        last_rd = 8'h80;
        for (int i = 0; i < 400 && last_rd[7] === 1'b1; i++)
            rd(fmt_pkg::ADDR_CONDITION, 32'h0, 32'h0);
        // a poll that runs out counts as a mismatch
        check({24'h0, last_rd & 8'h80}, 32'h0);
    endtask
    // results noted by the drivers are compared as they appear
    always @(posedge clk) begin
        if (psel && penable && !pwrite && pready) begin
            last_rd = prdata[7:0];
            if (rd_q[0][63:32] != 32'h0)
                check(prdata & rd_q[0][63:32], rd_q[0][31:0]);
            void'(rd_q.pop_front());
        end
        if (m_wr && m_ack) begin
            if (lba_q.size() == 0) check({4'h0, m_lba}, 32'hFFFFFFFF);
            else check({4'h0, m_lba}, {4'h0, lba_q.pop_front()});
        end
    end
    task automatic fmt(input logic [27:0] ad, input logic chs,
            input logic [27:0] s, input logic [7:0] err);
        wr(fmt_pkg::ADDR_LOW, ad[7:0]);
        wr(fmt_pkg::ADDR_MID, ad[15:8]);
        wr(fmt_pkg::ADDR_HIGH, ad[23:16]);
        wr(fmt_pkg::ADDR_DEVHEAD, {1'b1, !chs, 2'b10, ad[27:24]});
        wr(fmt_pkg::ADDR_TABLE, 8'($random(seed)));
        for (int i = 0; i < 63 && err == 8'h00; i++)
            lba_q.push_back(s + 28'(i));
        wr(fmt_pkg::ADDR_OPCODE, fmt_pkg::OP_FORMAT_TRACK);
        wait_idle();
        rd(fmt_pkg::ADDR_FAILURE, {24'h0, err}, 32'hFF);
        rd(fmt_pkg::ADDR_CONDITION, {31'h28, err != 8'h00}, 32'hFF);
        if (!chs && err == 8'h00) begin
            s = s + 28'd62;
            rd(fmt_pkg::ADDR_LOW, {24'h0, s[7:0]}, 32'hFF);
            rd(fmt_pkg::ADDR_MID, {24'h0, s[15:8]}, 32'hFF);
            rd(fmt_pkg::ADDR_HIGH, {24'h0, s[23:16]}, 32'hFF);
            rd(fmt_pkg::ADDR_DEVHEAD, {28'h0, s[27:24]}, 32'hF);
        end
    endtask
    initial begin
        #200000;
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(fmt_pkg::ADDR_CONDITION, 32'h50, 32'hFF);
        rd(8'h40, 32'h0, 32'h0);
        wr(fmt_pkg::ADDR_IRQ_MASK, 8'h03);
        repeat (3) begin
            a = 28'($random(seed));
            a = a & 28'h7FFFF;
            fmt(a, 1'b0, a - a % 28'd63, 8'h00);
            check({31'h0, irq}, 32'h1);
            rd(fmt_pkg::ADDR_IRQ_STAT, 32'h1, 32'h3);
            wr(fmt_pkg::ADDR_IRQ_STAT, 8'h01);
            @(posedge clk);
            check({31'h0, irq}, 32'h0);
        end
        fmt(fmt_pkg::NATIVE_MAX_LBA + 28'h1, 1'b0, 28'h0, 8'h14);
        rd(fmt_pkg::ADDR_IRQ_STAT, 32'h2, 32'h3);
        wr(fmt_pkg::ADDR_IRQ_MASK, 8'h00);
        wr(fmt_pkg::ADDR_IRQ_STAT, 8'h03);
        c = 16'($random(seed));
        c = c % 16'h0410;
        a = {c[3:0], c, 8'h01};
        fmt(a, 1'b1, ({12'h0, c} * 28'd16 + c[3:0]) * 28'd63, 8'h00);
        fmt({4'h0, 16'h0410, 8'h01}, 1'b1, 28'h0, 8'h04);
        check({31'h0, irq}, 32'h0);
        wr(fmt_pkg::ADDR_IRQ_MASK, 8'h03);
        @(posedge clk);
        check({31'h0, irq}, 32'h1);
        wr(fmt_pkg::ADDR_IRQ_STAT, 8'h03);
        // lba mode with an out-of-range address left over
        wr(fmt_pkg::ADDR_DEVHEAD, 8'hEF);
        wr(fmt_pkg::ADDR_OPCODE, fmt_pkg::OP_FORMAT_UNIT);
        wait_idle();
        rd(fmt_pkg::ADDR_FAILURE, 32'h04, 32'hFF);
        wr(fmt_pkg::ADDR_DEFECTS, 8'h05);
        wr(fmt_pkg::ADDR_FEATURE, 8'h11);
        wr(fmt_pkg::ADDR_OPCODE, fmt_pkg::OP_ERASE_PREP);
        wait_idle();
        flt_lba <= 28'h4;
        for (int i = 0; i < 4; i++) lba_q.push_back(28'(i));
        wr(fmt_pkg::ADDR_OPCODE, fmt_pkg::OP_FORMAT_UNIT);
        rd(fmt_pkg::ADDR_CONDITION, 32'h80, 32'hAC);
        wait_idle();
        rd(fmt_pkg::ADDR_DEFECTS, 32'h05, 32'hFF);
        rd(fmt_pkg::ADDR_IRQ_STAT, 32'h2, 32'h2);
        rd(fmt_pkg::ADDR_TABLE, 32'h6, 32'hFF);
        check(32'(lba_q.size()), 32'h0);
        tally_and_finish();
    end
endmodule
